// *** rtl/fbc_top.sv ***
// Flyback gate sequencer with burst mode and protections, APB registers.
// Assumes comparator flags are synchronous to CLK_IN and APB is a proper master.
`timescale 1ns/1ps
`include "fbc_defines.svh"
module fbc_top
	import fbc_pkg::*;
#(
	parameter int OLP_CYC = `FBC_OLP_CYC,
	parameter int BNO_CYC = `FBC_BNO_CYC,
	parameter int PERIOD_CYC = `FBC_PERIOD_CYC
) (
	// Clock and reset
	input  wire logic        CLK_IN,
	input  wire logic        SYS_RST_IN,
	// APB slave
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [11:0] PADDR_IN,
	input  wire logic [31:0] PWDATA_IN,
	output logic      [31:0] PRDATA_OUT,
	output logic             PREADY_OUT,
	output logic             PSLVERR_OUT,
	// Feedback comparators
	input  wire logic        FB_BELOW_ENTRY_IN,
	input  wire logic        FB_ABOVE_EXIT_IN,
	input  wire logic        FB_ABOVE_OLP_IN,
	// Supply, temperature and current sense
	input  wire logic        VCC_OVP_IN,
	input  wire logic        OTP_IN,
	input  wire logic        CS_LIMIT_IN,
	// Demag pin comparators
	input  wire logic        DEMAG_DONE_IN,
	input  wire logic        VALLEY_IN,
	input  wire logic        LINE_ABOVE_BNI_IN,
	input  wire logic        LINE_BELOW_BNO_IN,
	input  wire logic        LINE_ABOVE_LNO_IN,
	input  wire logic        DEM_ABOVE_OVP_IN,
	input  wire logic        DEM_BELOW_UVP_IN,
	// Gate drive
	output logic             GATE_OUT
);

	localparam fbc_cnt_t LEB    = 12'(`FBC_LEB_CYC);
	localparam fbc_cnt_t PERIOD = 12'(PERIOD_CYC);
	localparam fbc_cnt_t MAX_ON = 12'(PERIOD_CYC * `FBC_DUTY_MAX_PCT / 100);
	localparam fbc_cnt_t DEM_SP = 12'(`FBC_DEM_SAMPLE_CYC);
	localparam fbc_cnt_t VTMO   = 12'(`FBC_VALLEY_TMO_CYC);

	fbc_state_e  state;
	fbc_state_e  next_state;
	fbc_cnt_t    cyc_cnt;
	fbc_cnt_t    on_cnt;
	fbc_cnt_t    wait_cnt;
	fbc_cnt_t    dem_cnt;
	logic        dem_arm;
	logic        dem_tick;
	logic        dcm;
	logic        burst;
	logic        brown_in;
	logic        bno_low;
	logic        uvp;
	logic        run_ok;
	logic        period_tick;
	logic        turn_off;
	logic        line_tick;
	logic        ocp_hit;
	logic [31:0] ctrl;
	logic [7:0]  events;
	logic [7:0]  ev_set;
	logic        wr_en;
	logic        rd_setup;
	logic        addr_ok;

	fbc_qual_if q_bni ();
	fbc_qual_if q_bno ();
	fbc_qual_if q_lno ();
	fbc_qual_if q_ovp ();
	fbc_qual_if q_olp ();

	// Everything that must keep the gate low
	assign run_ok = ctrl[`FBC_CTRL_EN_BIT] && !burst && !VCC_OVP_IN
		&& !OTP_IN && !q_olp.qual && brown_in && !q_lno.qual
		&& !q_ovp.qual && !(ctrl[`FBC_CTRL_UVP_BIT] && uvp);

	assign period_tick = (cyc_cnt == PERIOD - 12'h001);
	assign ocp_hit     = (on_cnt >= LEB) && CS_LIMIT_IN;
	assign turn_off    = (state == ST_ON) && (next_state != ST_ON);

	// Gate sequencer; blanking hides the turn-on spike from the limiter
	always_comb begin
		next_state = state;
		unique case (state)
			ST_OFF: begin
				if (period_tick && run_ok)
					next_state = dcm ? ST_VALLEY : ST_ON;
			end
			ST_ON: begin
				if (!run_ok || ocp_hit || on_cnt >= MAX_ON - 12'h001)
					next_state = ST_OFF;
			end
			ST_VALLEY: begin
				if (!run_ok)
					next_state = ST_OFF;
				else if (VALLEY_IN || wait_cnt >= VTMO)
					next_state = ST_ON;
			end
			default: next_state = ST_OFF;
		endcase
	end

	// State and registered gate
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			state    <= ST_OFF;
			GATE_OUT <= 1'b0;
		end else begin
			state    <= next_state;
			GATE_OUT <= (next_state == ST_ON);
		end
	end

	// Period restarts at each turn-on, free runs while idle
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN)
			cyc_cnt <= '0;
		else if ((state != ST_ON && next_state == ST_ON) || period_tick)
			cyc_cnt <= '0;
		else
			cyc_cnt <= cyc_cnt + 12'h001;
	end

	// On-time and valley wait counters
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			on_cnt   <= '0;
			wait_cnt <= '0;
		end else begin
			on_cnt   <= (next_state == ST_ON && state == ST_ON) ? on_cnt + 12'h001 : '0;
			wait_cnt <= (state == ST_VALLEY) ? wait_cnt + 12'h001 : '0;
		end
	end

	// Demag completion during off-time marks DCM
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN)
			dcm <= 1'b0;
		else if (next_state == ST_ON && state != ST_ON)
			dcm <= 1'b0;
		else if (state != ST_ON && DEMAG_DONE_IN)
			dcm <= 1'b1;
	end

	// Burst hysteresis between entry and exit levels
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN)
			burst <= 1'b0;
		else if (burst && FB_ABOVE_EXIT_IN)
			burst <= 1'b0;
		else if (FB_BELOW_ENTRY_IN)
			burst <= 1'b1;
	end

	// Demag sample timer; a new turn-on abandons a pending sample
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			dem_arm <= 1'b0;
			dem_cnt <= '0;
		end else if (turn_off) begin
			dem_arm <= 1'b1;
			dem_cnt <= '0;
		end else if (dem_arm) begin
			dem_cnt <= dem_cnt + 12'h001;
			if (dem_tick || next_state == ST_ON)
				dem_arm <= 1'b0;
		end
	end

	assign dem_tick = dem_arm && (dem_cnt == DEM_SP - 12'h001);

	// Under-voltage from the same sample, re-probed at idle period ends while set
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN)
			uvp <= 1'b0;
		else if (dem_tick)
			uvp <= DEM_BELOW_UVP_IN;
		else if (uvp && period_tick && !dem_arm && state != ST_ON)
			uvp <= DEM_BELOW_UVP_IN;
	end

	// Line current taken at end of each on-time; probe ticks until brown-in
	assign line_tick = turn_off || (!brown_in && period_tick);

	// Brown-out level is held between line samples
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN)
			bno_low <= 1'b0;
		else if (line_tick && brown_in)
			bno_low <= LINE_BELOW_BNO_IN;
		else if (!brown_in)
			bno_low <= 1'b0; // Stale sample would trip a fresh brown-in
	end

	// Brown-in set and brown-out clear
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN)
			brown_in <= 1'b0;
		else if (q_bno.qual)
			brown_in <= 1'b0;
		else if (q_bni.qual)
			brown_in <= 1'b1;
	end

	// Qualifier hookups
	// Run cleared while browned-in, so recovery needs a fresh run
	assign q_bni.cond = LINE_ABOVE_BNI_IN && !brown_in;
	assign q_bni.tick = line_tick || brown_in;
	assign q_bno.cond = bno_low && brown_in;
	assign q_bno.tick = 1'b1;
	assign q_lno.cond = LINE_ABOVE_LNO_IN;
	// A tripped qualifier is probed at period ends, else it could never clear
	assign q_lno.tick = line_tick || (q_lno.qual && period_tick);
	assign q_ovp.cond = DEM_ABOVE_OVP_IN;
	assign q_ovp.tick = dem_tick || (q_ovp.qual && period_tick);
	assign q_olp.cond = FB_ABOVE_OLP_IN;
	assign q_olp.tick = 1'b1;

	fbc_qual #(.CW(4), .LIMIT(24'(`FBC_BNI_CYCLES + 1))) u_bni (
		.clk_in (CLK_IN),
		.rst_in (SYS_RST_IN),
		.q      (q_bni)
	);
	fbc_qual #(.CW(24), .LIMIT(24'(BNO_CYC))) u_bno (
		.clk_in (CLK_IN),
		.rst_in (SYS_RST_IN),
		.q      (q_bno)
	);
	fbc_qual #(.CW(4), .LIMIT(24'(`FBC_LNO_CYCLES + 1))) u_lno (
		.clk_in (CLK_IN),
		.rst_in (SYS_RST_IN),
		.q      (q_lno)
	);
	fbc_qual #(.CW(4), .LIMIT(24'(`FBC_OVP_CYCLES))) u_ovp (
		.clk_in (CLK_IN),
		.rst_in (SYS_RST_IN),
		.q      (q_ovp)
	);
	fbc_qual #(.CW(24), .LIMIT(24'(OLP_CYC))) u_olp (
		.clk_in (CLK_IN),
		.rst_in (SYS_RST_IN),
		.q      (q_olp)
	);

	// APB decode; zero wait states
	assign wr_en       = PSEL_IN && PENABLE_IN && PWRITE_IN;
	assign rd_setup    = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
	assign addr_ok     = (PADDR_IN == `FBC_REG_CTRL) || (PADDR_IN == `FBC_REG_STATUS)
		|| (PADDR_IN == `FBC_REG_EVENT);
	assign PREADY_OUT  = 1'b1;
	assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !addr_ok;

	// Control register steers enable and the under-voltage shutdown
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN)
			ctrl <= `FBC_CTRL_RST;
		else if (wr_en && PADDR_IN == `FBC_REG_CTRL)
			ctrl <= {30'h0, PWDATA_IN[1:0]};
	end

	// Sticky events; hardware set wins over a write-one clear
	always_comb begin
		ev_set = 8'h00;
		ev_set[`FBC_EV_VCC_OVP] = VCC_OVP_IN;
		ev_set[`FBC_EV_OTP]     = OTP_IN;
		ev_set[`FBC_EV_OLP]     = q_olp.qual;
		ev_set[`FBC_EV_LNO]     = q_lno.qual;
		ev_set[`FBC_EV_BNO]     = q_bno.qual;
		ev_set[`FBC_EV_OVP]     = q_ovp.qual;
		ev_set[`FBC_EV_UVP]     = uvp;
		ev_set[`FBC_EV_OCP]     = (state == ST_ON) && ocp_hit;
	end

	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN)
			events <= 8'h00;
		else if (wr_en && PADDR_IN == `FBC_REG_EVENT)
			events <= (events & ~PWDATA_IN[7:0]) | ev_set;
		else
			events <= events | ev_set;
	end

	// Read data registered in the setup cycle, valid in the access cycle
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN)
			PRDATA_OUT <= 32'h0;
		else if (rd_setup) begin
			unique case (PADDR_IN)
				`FBC_REG_CTRL:   PRDATA_OUT <= ctrl;
				`FBC_REG_STATUS: PRDATA_OUT <= {22'h0, state, uvp, q_ovp.qual, q_lno.qual,
					q_olp.qual, brown_in, dcm, burst, GATE_OUT};
				`FBC_REG_EVENT:  PRDATA_OUT <= {24'h0, events};
				default:         PRDATA_OUT <= 32'h0;
			endcase
		end
	end

	a_burst_gate: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
		burst |=> !GATE_OUT)
		else $error("gate high during burst idle");

	a_burst_exit: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
		(burst && !FB_ABOVE_EXIT_IN) |=> burst)
		else $error("burst left below exit level");

	a_vcc_halt: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
		VCC_OVP_IN |=> !GATE_OUT)
		else $error("gate high during supply over-voltage");

	a_otp_halt: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
		OTP_IN |=> !GATE_OUT)
		else $error("gate high during over-temperature");

	a_olp_short: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
		!FB_ABOVE_OLP_IN |=> !q_olp.qual)
		else $error("overload kept after short excursion");

	a_leb_mask: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
		(state == ST_ON && on_cnt < LEB - 12'h001 && run_ok) |=> state == ST_ON)
		else $error("on-time ended inside blanking");

	a_ocp_end: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
		(state == ST_ON && on_cnt >= LEB && CS_LIMIT_IN) |=> !GATE_OUT)
		else $error("current limit did not end on-time");

	a_valley_on: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
		(state == ST_VALLEY && VALLEY_IN && run_ok) |=> GATE_OUT)
		else $error("no turn-on at valley");

	a_prot_low: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
		(q_lno.qual || q_ovp.qual || q_olp.qual || !brown_in) |=> !GATE_OUT)
		else $error("gate high while protected");

	a_line_gate: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
		(line_tick && brown_in) |-> state == ST_ON)
		else $error("line current taken with gate off");

endmodule : fbc_top

// *** include/fbc_defines.svh ***
// Constants of the flyback mode and protection controller.
// Assumes a 200 MHz core clock; all clock-cycle counts but the valley timeout derive from it.
`ifndef FBC_DEFINES_SVH
`define FBC_DEFINES_SVH

// Clock and times in their own units
`define FBC_CLK_MHZ          200
`define FBC_LEB_NS           350
`define FBC_DEM_SAMPLE_US    3
`define FBC_OLP_MS           45
`define FBC_BNO_MS           60
`define FBC_FSW_KHZ          65
`define FBC_DUTY_MAX_PCT     64

// Derived cycle counts (least times round up)
`define FBC_LEB_CYC          ((`FBC_LEB_NS * `FBC_CLK_MHZ + 999) / 1000)
`define FBC_DEM_SAMPLE_CYC   (`FBC_DEM_SAMPLE_US * `FBC_CLK_MHZ)
`define FBC_OLP_CYC          (`FBC_OLP_MS * 1000 * `FBC_CLK_MHZ)
`define FBC_BNO_CYC          (`FBC_BNO_MS * 1000 * `FBC_CLK_MHZ)
`define FBC_PERIOD_CYC       (`FBC_CLK_MHZ * 1000 / `FBC_FSW_KHZ)
`define FBC_MAX_ON_CYC       (`FBC_PERIOD_CYC * `FBC_DUTY_MAX_PCT / 100)
`define FBC_VALLEY_TMO_CYC   600

// Debounce in switching cycles
`define FBC_BNI_CYCLES       7
`define FBC_LNO_CYCLES       7
`define FBC_OVP_CYCLES       7

// Register offsets
`define FBC_REG_CTRL         12'h000
`define FBC_REG_STATUS       12'h004
`define FBC_REG_EVENT        12'h008

// Control fields and reset value
`define FBC_CTRL_EN_BIT      0
`define FBC_CTRL_UVP_BIT     1
`define FBC_CTRL_RST         32'h0000_0001

// Event bit positions
`define FBC_EV_VCC_OVP       0
`define FBC_EV_OTP           1
`define FBC_EV_OLP           2
`define FBC_EV_LNO           3
`define FBC_EV_BNO           4
`define FBC_EV_OVP           5
`define FBC_EV_UVP           6
`define FBC_EV_OCP           7

`endif

// *** include/fbc_pkg.sv ***
// Types of the flyback mode and protection controller.
// Assumes the defines header carries all numbers.
package fbc_pkg;

	// Gate sequencer states
	typedef enum logic [1:0] {
		ST_OFF    = 2'b00,
		ST_ON     = 2'b01,
		ST_VALLEY = 2'b10
	} fbc_state_e;

	typedef logic [11:0] fbc_cnt_t;

endpackage : fbc_pkg

// *** include/fbc_qual_if.sv ***
// Link between the controller and one debounce qualifier.
// Assumes both ends share the controller clock.
`timescale 1ns/1ps
interface fbc_qual_if;
	logic cond;
	logic tick;
	logic qual;

	modport user (output cond, output tick, input qual);
	modport qual_end (input cond, input tick, output qual);
endinterface : fbc_qual_if

// *** rtl/fbc_qual.sv ***
// Consecutive-tick debounce qualifier.
// Assumes tick and cond are synchronous single-clock signals.
`timescale 1ns/1ps
module fbc_qual #(
	parameter int          CW    = 24,
	parameter logic [23:0] LIMIT = 24'h000007
) (
	// Clock and reset
	input  wire logic  clk_in,
	input  wire logic  rst_in,
	// Condition in, qualified level out
	fbc_qual_if.qual_end q
);

	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic [CW-1:0] lim;

	assign lim = LIMIT[CW-1:0];

	// Any tick without the condition restarts the run
	always_comb begin
		next_cnt = cnt;
		if (q.tick) begin
			if (!q.cond)
				next_cnt = '0;
			else if (cnt != lim)
				next_cnt = cnt + 1'b1;
		end
	end

	// Counter saturates so qual stays high while the run lasts
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt    <= '0;
			q.qual <= 1'b0;
		end else begin
			cnt    <= next_cnt;
			q.qual <= (next_cnt == lim);
		end
	end

	a_qual_run: assert property (@(posedge clk_in) disable iff (rst_in)
		$rose(q.qual) |-> (cnt == lim) && $past(q.cond))
		else $error("qualifier rose before its full run");

	a_qual_drop: assert property (@(posedge clk_in) disable iff (rst_in)
		(q.tick && !q.cond) |=> !q.qual)
		else $error("qualifier held after condition cleared");

endmodule : fbc_qual

// *** dv/fbc_stage_model.sv ***
// Flyback stage model: current ramp and demag ringing.
// Assumes the gate and the clock come from the bench.
`timescale 1ns/1ps
module fbc_stage_model (
	// Clock and gate
	input  wire logic        clk_in,
	input  wire logic        gate_in,
	// Test knobs
	input  wire logic [11:0] cs_delay_in,
	input  wire logic        dcm_in,
	// Comparator flags
	output logic             cs_limit_out,
	output logic             demag_done_out,
	output logic             valley_out
);
	int on_cnt;
	int off_cnt;

	// Cycles since the last gate edge
	always_ff @(posedge clk_in) begin
		on_cnt  <= gate_in ? on_cnt + 1 : 0;
		off_cnt <= gate_in ? 0 : off_cnt + 1;
	end

	// Ramp reaches the limit after the set delay; zero means never
	assign cs_limit_out   = gate_in && cs_delay_in != 0 && on_cnt >= cs_delay_in;
	// Ringing gives a valley every 200 cycles, so a late gate still finds one
	assign demag_done_out = dcm_in && !gate_in && off_cnt >= 100;
	assign valley_out     = demag_done_out && off_cnt % 200 == 0;
endmodule : fbc_stage_model

// *** dv/fbc_tb_top.sv ***
// Bench for the flyback controller: APB tasks and gate timing checks.
// Assumes the stage model drives the sense flags; ends itself.
`timescale 1ns/1ps
`include "fbc_defines.svh"
module fbc_tb_top;
	localparam int PER = 1000;
	localparam int LEB = `FBC_LEB_CYC;
	localparam int MON = PER * `FBC_DUTY_MAX_PCT / 100;
	logic        clk, rst, psel, pen, pwr, pready, pslverr, gate;
	logic [11:0] paddr, cs_delay;
	logic [31:0] pwdata, prdata, rdata;
	logic [5:0]  prot;
	logic        bni, fb_below, fb_exit, fb_olp, dcm, cs_lim, demag, valley;
	int          bad_count, cmp_count, cyc, meas, vage, t;
	int          ebit [6] = '{0, 1, 3, 5, 6, 4};
	int          npul [6] = '{0, 0, 7, 6, 0, 0};

	// Short period, overload and brown-out times keep the run brief
	fbc_top #(.OLP_CYC(50), .BNO_CYC(50), .PERIOD_CYC(PER)) dut (
		.CLK_IN(clk), .SYS_RST_IN(rst),
		.PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
		.PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
		.FB_BELOW_ENTRY_IN(fb_below), .FB_ABOVE_EXIT_IN(fb_exit),
		.FB_ABOVE_OLP_IN(fb_olp), .VCC_OVP_IN(prot[0]), .OTP_IN(prot[1]),
		.CS_LIMIT_IN(cs_lim), .DEMAG_DONE_IN(demag), .VALLEY_IN(valley),
		.LINE_ABOVE_BNI_IN(bni & ~prot[5]), .LINE_BELOW_BNO_IN(prot[5]),
		.LINE_ABOVE_LNO_IN(prot[2]), .DEM_ABOVE_OVP_IN(prot[3]),
		.DEM_BELOW_UVP_IN(prot[4]), .GATE_OUT(gate)
	);
	fbc_stage_model model (
		.clk_in(clk), .gate_in(gate), .cs_delay_in(cs_delay), .dcm_in(dcm),
		.cs_limit_out(cs_lim), .demag_done_out(demag), .valley_out(valley)
	);

	// Clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Hang guard and age of the last valley
	always @(posedge clk) begin
		cyc  <= cyc + 1;
		vage <= valley ? 0 : vage + 1;
		if (cyc == 100000) begin
			bad_count++;
			report_and_stop();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			input logic err);
		@(posedge clk);
		psel   <= 1'b1;
		pwr    <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rdata = prdata;
		check(pslverr, err);
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask : apb

	task automatic wait_gate(input logic lvl, input int lim);
		meas = 0;
		while (gate !== lvl && meas < lim) begin
			@(posedge clk);
			meas++;
		end
		check(gate, lvl);
	endtask : wait_gate

	task automatic hold_low(input int c);
		int hi;
		hi = 0;
		repeat (c) begin
			@(posedge clk);
			if (gate !== 1'b0)
				hi++;
		end
		check(hi, 0);
	endtask : hold_low

	// Gate starts seen until the gate stays low for quiet cycles
	task automatic count_pulses(input int quiet);
		int   low;
		logic last;
		low  = 0;
		last = gate;
		meas = 0;
		while (low < quiet && meas < 20) begin
			@(posedge clk);
			if (gate === 1'b1 && last !== 1'b1)
				meas++;
			low  = (gate === 1'b1) ? 0 : low + 1;
			last = gate;
		end
	endtask : count_pulses

	// Length of the next full on-time with the given ramp delay
	task automatic on_time(input logic [11:0] d);
		cs_delay <= d;
		wait_gate(1'b0, 4000);
		wait_gate(1'b1, PER + 700);
		meas = 0;
		while (gate === 1'b1 && meas < 4000) begin
			@(posedge clk);
			meas++;
		end
	endtask : on_time

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop

	// Main sequence
	initial begin
		rst      = 1'b1;
		psel     = 1'b0;
		pen      = 1'b0;
		pwr      = 1'b0;
		paddr    = 12'h000;
		pwdata   = 32'h0;
		prot     = 6'h00;
		bni      = 1'b0;
		fb_below = 1'b0;
		fb_exit  = 1'b1;
		fb_olp   = 1'b0;
		dcm      = 1'b0;
		cs_delay = 12'h000;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, 12'h000, 32'h0, 1'b0);
		check(rdata, 32'h1);
		apb(1'b0, 12'h004, 32'h0, 1'b0);
		check(rdata & 32'h9, 32'h0);
		apb(1'b1, 12'h010, 32'hffff_ffff, 1'b1);
		apb(1'b0, 12'h010, 32'h0, 1'b1);
		check(rdata, 32'h0);
		$display("test registers done");
		bni <= 1'b1;
		hold_low(7 * PER);
		wait_gate(1'b1, 3 * PER);
		on_time(12'h000);
		check(meas >= MON - 1 && meas <= MON + 1, 1'b1);
		t = meas;
		wait_gate(1'b1, PER);
		check(t + meas >= PER - 2 && t + meas <= PER + 2, 1'b1);
		$display("test brown-in done");
		on_time(12'h00a);
		check(meas >= LEB && meas <= LEB + 3, 1'b1);
		on_time(12'h0c8);
		check(meas >= 200 && meas <= 203, 1'b1);
		apb(1'b0, 12'h008, 32'h0, 1'b0);
		check(rdata[7], 1'b1);
		apb(1'b1, 12'h008, 32'hff, 1'b0);
		$display("test current limit done");
		dcm <= 1'b1;
		repeat (3) begin
			wait_gate(1'b0, 4000);
			wait_gate(1'b1, PER + 700);
			check(vage <= 4, 1'b1);
		end
		dcm <= 1'b0;
		$display("test valley done");
		wait_gate(1'b1, PER + 700);
		fb_below <= 1'b1;
		fb_exit  <= 1'b0;
		repeat (3) @(posedge clk);
		check(gate, 1'b0);
		hold_low(1000);
		fb_below <= 1'b0;
		hold_low(PER + 100);
		fb_exit <= 1'b1;
		wait_gate(1'b1, PER + 700);
		$display("test burst done");
		wait_gate(1'b1, PER + 700);
		fb_olp <= 1'b1;
		repeat (40) @(posedge clk);
		fb_olp <= 1'b0;
		check(gate, 1'b1);
		wait_gate(1'b1, PER + 700);
		fb_olp <= 1'b1;
		repeat (55) @(posedge clk);
		check(gate, 1'b0);
		fb_olp <= 1'b0;
		apb(1'b0, 12'h008, 32'h0, 1'b0);
		check(rdata[2], 1'b1);
		apb(1'b1, 12'h008, 32'hff, 1'b0);
		$display("test overload done");
		// Shutdown enabled for output under-voltage too
		apb(1'b1, 12'h000, 32'h3, 1'b0);
		for (int i = 0; i < 6; i++) begin
			wait_gate(1'b1, 11 * PER);
			prot[i] <= 1'b1;
			if (i < 2) begin
				repeat (3) @(posedge clk);
				check(gate, 1'b0);
			end
			count_pulses(PER + 100);
			check(gate, 1'b0);
			check(meas, npul[i]);
			hold_low(1000);
			apb(1'b0, 12'h008, 32'h0, 1'b0);
			check(rdata[ebit[i]], 1'b1);
			prot[i] <= 1'b0;
			apb(1'b1, 12'h008, 32'hff, 1'b0);
			$display("test protection %0d done", i);
		end
		wait_gate(1'b1, 11 * PER);
		$display("test recovery done");
		report_and_stop();
	end
endmodule : fbc_tb_top
